// ==== bench/adcrp_host_model.sv ====
// Host model that frames and steps readouts on the chip select and read strobe pins.
`timescale 1ns/1ps
`default_nettype none

module adcrp_host_model (
	input wire logic clk, // System clock.
	input wire logic [15:0] db, // Resolved data bus level.
	input wire logic flag, // First channel flag value.
	input wire logic flag_oe, // First channel flag enable.
	output logic cs_n, // Chip select, active low.
	output logic rd_n, // Read strobe, active low.
	output logic [15:0] host_drv // Host side levels of the bus pins.
);
	logic order = 1'b1;
	logic [15:0] pat = 16'hA5A5;

	// Idle pins start high; bit 14 carries the byte order setting.
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
	end

	// Undriven bus bits other than bit 14 toggle every cycle so that a stale value never passes.
	always @(negedge clk) begin
		pat <= ~pat;
	end
	assign host_drv = {pat[15], order, pat[13:0]};

	// ****************************************************************
	// Strobe tasks
	// ****************************************************************
	// Strobe levels are held four cycles so the synchronisers always see them.
	task automatic cs(input logic lvl);
		@(negedge clk);
		cs_n = lvl;
		repeat (4) @(negedge clk);
	endtask

	// One read pulse; with tied set, chip select follows the strobe.
	task automatic rd(input logic tied, output logic [15:0] v, output logic f,
		output logic foe);
		@(negedge clk);
		rd_n = 1'b0;
		if (tied) cs_n = 1'b0;
		repeat (4) @(negedge clk);
		v = db;
		f = flag;
		foe = flag_oe;
		rd_n = 1'b1;
		if (tied) cs_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
endmodule

`default_nettype wire

// ==== bench/adcrp_readout_test.sv ====
// Self-checking testbench of the ADC result readout port.
`timescale 1ns/1ps
`default_nettype none

module adcrp_readout_test;
	import adcrp_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic conv_start = 1'b0;
	logic conv_done = 1'b0;
	logic isel = 1'b0;
	logic bsel = 1'b0;
	adcrp_bank_t conv_data = '0;
	adcrp_bank_t bank = '0;
	logic [15:0] db_out, db_oe, db_in, host_drv;
	logic cs_n, rd_n, flag, flag_oe, busy;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;

	// ****************************************************************
	// Clock, bus resolution and instances
	// ****************************************************************
	always #50 clk = ~clk;
	assign db_in = (db_oe & db_out) | (~db_oe & host_drv);

	adcrp_readout adcrp_readout_inst (.clk(clk), .reset_n(reset_n), .conv_start(conv_start),
		.conv_done(conv_done), .conv_data(conv_data), .cs_n(cs_n), .rd_n(rd_n),
		.interface_select_pin(isel), .byte_or_serial_select_pin(bsel), .db_in(db_in),
		.db_out(db_out), .db_oe(db_oe), .first_channel_flag(flag),
		.first_channel_flag_oe(flag_oe), .busy(busy));

	adcrp_host_model adcrp_host_model_inst (.clk(clk), .db(db_in), .flag(flag),
		.flag_oe(flag_oe), .cs_n(cs_n), .rd_n(rd_n), .host_drv(host_drv));

	// A hang is cut short well beyond the roughly nine hundred cycles the run needs.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Expected word or byte of transfer k within a frame.
	function automatic logic [15:0] expw(input logic byte_m, input logic ord, input int k);
		logic [17:0] r;
		logic [23:0] p;
		int part;
		r = bank[byte_m ? k / 3 : k / 2];
		p = {r, 6'h00};
		part = byte_m ? k % 3 : k % 2;
		if (!byte_m) return (part == 0) ? r[17:2] : {r[1:0], 14'h0000};
		return {8'h00, p[8 * (ord ? 2 - part : part) +: 8]};
	endfunction

	task complete_run();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Conversion, optionally with a read during busy that must see the old sample.
	task automatic conv(input logic [17:0] base, input logic mid);
		logic [15:0] v;
		logic f, foe;
		@(negedge clk) conv_start = 1'b1;
		@(negedge clk) conv_start = 1'b0;
		repeat (2) @(negedge clk);
		chk(busy, 1'b1);
		if (mid) begin
			isel = 1'b0;
			adcrp_host_model_inst.cs(1'b0);
			adcrp_host_model_inst.rd(1'b0, v, f, foe);
			adcrp_host_model_inst.cs(1'b1);
			chk(v, expw(1'b0, 1'b0, 0));
		end
		for (int i = 0; i < 8; i++) bank[i] = base + 18'(i) * 18'h0B1D3;
		@(negedge clk) conv_data = bank;
		conv_done = 1'b1;
		@(negedge clk) conv_done = 1'b0;
		conv_data = ~bank;
		repeat (2) @(negedge clk);
		chk(busy, 1'b0);
	endtask

	// Frame with separate strobes; n transfers from channel 1 onwards.
	task automatic frame(input logic is, input logic bs, input logic ord, input int n);
		logic [15:0] v;
		logic f, foe;
		@(negedge clk) isel = is;
		bsel = bs;
		adcrp_host_model_inst.order = ord;
		adcrp_host_model_inst.cs(1'b0);
		chk(db_oe, is ? ADCRP_OE_BYTE : ADCRP_OE_WORD);
		for (int k = 0; k < n; k++) begin
			adcrp_host_model_inst.rd(1'b0, v, f, foe);
			chk(is ? {24'h000000, v[7:0]} : {16'h0000, v}, expw(is, ord, k));
			chk({f, foe}, {k < (is ? 3 : 2), 1'b1});
		end
		adcrp_host_model_inst.cs(1'b1);
		chk({db_oe, flag_oe}, 17'h00000);
	endtask

	// Tied strobes: the combined falling edge enables the bus with channel 1 high word.
	task automatic tied_read();
		logic [15:0] v;
		logic f, foe;
		@(negedge clk) isel = 1'b0;
		bsel = 1'b0;
		adcrp_host_model_inst.rd(1'b1, v, f, foe);
		chk({f, foe, v}, {2'b11, expw(1'b0, 1'b0, 0)});
		chk(db_oe, ADCRP_OE_NONE);
	endtask

	// Serial mode keeps this port released and ignores read strobes; so does a high chip select.
	// The next frame starts at channel 1 only if the ignored strobe left the pointer alone.
	task automatic serial();
		logic [15:0] v;
		logic f, foe;
		@(negedge clk) isel = 1'b1;
		bsel = 1'b0;
		adcrp_host_model_inst.cs(1'b0);
		adcrp_host_model_inst.rd(1'b0, v, f, foe);
		chk({db_oe, foe}, 17'h00000);
		adcrp_host_model_inst.cs(1'b1);
		@(negedge clk) isel = 1'b0;
		adcrp_host_model_inst.rd(1'b0, v, f, foe);
		chk({db_oe, foe}, 17'h00000);
	endtask

	// Reset in mid-frame and mid-conversion: outputs drop, busy ends, bank clears.
	// Three reads leave the pointer on channel 2, so a kept pointer shows in the flag.
	task automatic mid_reset();
		logic [15:0] v;
		logic f, foe;
		@(negedge clk) isel = 1'b0;
		bsel = 1'b0;
		conv_start = 1'b1;
		@(negedge clk) conv_start = 1'b0;
		adcrp_host_model_inst.cs(1'b0);
		repeat (3) adcrp_host_model_inst.rd(1'b0, v, f, foe);
		reset_n = 1'b0;
		@(negedge clk);
		chk(db_out, ADCRP_DB_RESET);
		chk({db_oe, flag_oe, busy}, 18'h00000);
		adcrp_host_model_inst.cs(1'b1);
		reset_n = 1'b1;
		bank = '0;
		frame(1'b0, 1'b0, 1'b0, 4);
	endtask

	// Main sequence; the byte frames take all 24 transfers.
	initial begin
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		conv(18'h34567, 1'b0);
		frame(1'b0, 1'b0, 1'b0, 16);
		frame(1'b1, 1'b1, 1'b1, 24);
		frame(1'b1, 1'b1, 1'b0, 24);
		tied_read();
		serial();
		frame(1'b0, 1'b1, 1'b0, 4);
		conv(18'h1C0DE, 1'b1);
		frame(1'b0, 1'b0, 1'b0, 4);
		mid_reset();
		complete_run();
	end
endmodule

`default_nettype wire

// ==== hdl/adcrp_pkg.sv ====
// Package of constants and types for the ADC result parallel readout port.
package adcrp_pkg;

	// ****************************************************************
	// Sizes of the result bank and of the readout frame
	// ****************************************************************
	localparam int ADCRP_NUM_CH = 8;
	localparam int ADCRP_RES_W = 18;
	localparam int ADCRP_BUS_W = 16;
	localparam int ADCRP_CH_W = 3;
	localparam int ADCRP_PART_W = 2;
	localparam int ADCRP_PAD_W = 6;
	localparam int ADCRP_LOW_W = 2;
	localparam int ADCRP_BYTE_W = 8;

	// ****************************************************************
	// Positions, codes and reset values
	// ****************************************************************
	// Last transfer index within one channel: two words or three bytes.
	localparam logic [ADCRP_PART_W-1:0] ADCRP_LAST_PAR = 2'h1;
	localparam logic [ADCRP_PART_W-1:0] ADCRP_LAST_BYTE = 2'h2;
	localparam logic [ADCRP_PART_W-1:0] ADCRP_PART_FIRST = 2'h0;
	localparam logic [ADCRP_PART_W-1:0] ADCRP_PART_ONE = 2'h1;
	localparam logic [ADCRP_CH_W-1:0] ADCRP_CH_FIRST = 3'h0;
	localparam logic [ADCRP_CH_W-1:0] ADCRP_CH_STEP = 3'h1;
	localparam logic [ADCRP_PART_W-1:0] ADCRP_PART_STEP = 2'h1;
	// Byte lane masks of the output enables, and the data bus reset value.
	localparam logic [ADCRP_BUS_W-1:0] ADCRP_OE_NONE = 16'h0000;
	localparam logic [ADCRP_BUS_W-1:0] ADCRP_OE_WORD = 16'hFFFF;
	localparam logic [ADCRP_BUS_W-1:0] ADCRP_OE_BYTE = 16'h00FF;
	localparam logic [ADCRP_BUS_W-1:0] ADCRP_DB_RESET = 16'h0000;
	// Bus bit that turns into the byte order input in byte mode.
	localparam int ADCRP_ORDER_BIT = 14;
	// Byte positions inside the padded 24-bit result.
	localparam int ADCRP_MSB_LO = 16;
	localparam int ADCRP_MID_LO = 8;
	localparam int ADCRP_LSB_LO = 0;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		ADCRP_MODE_PAR = 3'b001,
		ADCRP_MODE_BYTE = 3'b010,
		ADCRP_MODE_SER = 3'b100
	} adcrp_mode_e;

	typedef logic [ADCRP_RES_W-1:0] adcrp_res_t;
	typedef adcrp_res_t [ADCRP_NUM_CH-1:0] adcrp_bank_t;

	// Pin levels after the two flip-flop synchronisers.
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic isel;
		logic bsel;
		logic order;
	} adcrp_pins_s;

	// Whole state of the readout port.
	typedef struct packed {
		adcrp_pins_s sync1;
		adcrp_pins_s sync2;
		logic cs_n_d;
		logic rd_n_d;
		logic busy;
		adcrp_bank_t bank;
		logic [ADCRP_CH_W-1:0] chan;
		logic [ADCRP_PART_W-1:0] part;
		logic [ADCRP_BUS_W-1:0] db_out;
		logic [ADCRP_BUS_W-1:0] db_oe;
		logic flag;
		logic flag_oe;
	} adcrp_state_s;

endpackage

// ==== hdl/adcrp_readout.sv ====
// Parallel and byte readout port for the eight-channel ADC result bank.
//
// Contract
// - Result bank loads all eight channels when busy falls.
// - Reads after busy falls give new sample; reads during busy give previous.
// - Select 0 gives parallel; 1 with byte select 1 byte; else serial.
// - Combined strobe falling edge drives the 16-bit bus out of high impedance.
// - First read edge presents upper 16 bits of channel 1.
// - Second read edge gives two low bits on bits 15,14; rest low.
// - Remaining channels follow in ascending order, same two-word pattern.
// - Flag high during channel 1, low from third read edge in parallel.
// - Separate strobes: flag stays low, released on chip select rising.
// - Byte mode sends each channel as three bytes on the low lane.
// - In byte mode bus bit 14 input selects byte order.
// - Byte order is a static setting; low sends least significant first.
// - Byte mode enables low lane on chip select fall; reads step bytes.
// - Byte mode flag rises on first read, falls on fourth.
// - Byte mode flag stays low, then released on chip select rising.
// - Byte mode pads 18-bit result with six trailing zeros.
// - Busy high during conversion, low when all channels finished.
// - Ending a frame releases data bus and flag to high impedance.
`timescale 1ns/1ps
`default_nettype none

module adcrp_readout (
	input wire logic clk, // System clock, 10 MHz.
	input wire logic reset_n, // Synchronous reset, active low.
	input wire logic conv_start, // Pulse: conversion phase begins.
	input wire logic conv_done, // Pulse: all channels converted.
	input wire adcrp_pkg::adcrp_bank_t conv_data, // Fresh results, valid with conv_done.
	input wire logic cs_n, // Chip select pin, active low.
	input wire logic rd_n, // Read strobe pin, active low.
	input wire logic interface_select_pin, // Interface select pin.
	input wire logic byte_or_serial_select_pin, // Byte or serial select pin.
	input wire logic [adcrp_pkg::ADCRP_BUS_W-1:0] db_in, // Data bus pin levels.
	output logic [adcrp_pkg::ADCRP_BUS_W-1:0] db_out, // Data bus drive values.
	output logic [adcrp_pkg::ADCRP_BUS_W-1:0] db_oe, // Data bus enables, high drives.
	output logic first_channel_flag, // First channel flag value.
	output logic first_channel_flag_oe, // First channel flag enable.
	output logic busy // High while converting.
);
	import adcrp_pkg::*;

	// ****************************************************************
	// State and helper terms
	// ****************************************************************
	adcrp_state_s state_reg;
	adcrp_state_s state_next;
	adcrp_state_s state_rst;
	adcrp_mode_e mode;
	logic cs_now;
	logic rd_now;
	logic cs_fall;
	logic cs_rise;
	logic rd_fall;
	logic mode_act;
	logic rd_go;
	logic [ADCRP_PART_W-1:0] part_last;
	adcrp_res_t cur_res;
	logic [ADCRP_RES_W+ADCRP_PAD_W-1:0] padded;
	logic [ADCRP_PART_W-1:0] byte_sel;
	logic [ADCRP_BYTE_W-1:0] byte_val;
	logic [ADCRP_BUS_W-1:0] word_val;

	// Only the second synchroniser stage and its delayed copy are read here.
	assign cs_now = state_reg.sync2.cs_n;
	assign rd_now = state_reg.sync2.rd_n;
	assign cs_fall = state_reg.cs_n_d & ~cs_now;
	assign cs_rise = ~state_reg.cs_n_d & cs_now;
	assign rd_fall = state_reg.rd_n_d & ~rd_now;

	// Mode decode from the two select pins.
	always_comb begin
		case ({state_reg.sync2.isel, state_reg.sync2.bsel})
			2'b00: mode = ADCRP_MODE_PAR;
			2'b01: mode = ADCRP_MODE_PAR;
			2'b11: mode = ADCRP_MODE_BYTE;
			2'b10: mode = ADCRP_MODE_SER;
			default: mode = ADCRP_MODE_SER;
		endcase
	end

	// Serial readout lives elsewhere, so here serial counts as idle.
	assign mode_act = (mode == ADCRP_MODE_PAR) || (mode == ADCRP_MODE_BYTE);
	// A read edge with chip select low; covers tied strobes, where both fall together.
	assign rd_go = rd_fall && !cs_now && mode_act;
	assign part_last = (mode == ADCRP_MODE_BYTE) ? ADCRP_LAST_BYTE : ADCRP_LAST_PAR;

	// ****************************************************************
	// Output word formation
	// ****************************************************************
	// Data comes from the held bank, so reads during busy see the old sample.
	assign cur_res = state_reg.bank[state_reg.chan];
	assign padded = {cur_res, {ADCRP_PAD_W{1'b0}}};
	// The order input is read as a static level, not latched per frame.
	assign byte_sel = state_reg.sync2.order ? state_reg.part
		: (ADCRP_LAST_BYTE - state_reg.part);

	always_comb begin
		case (byte_sel)
			2'h0: byte_val = padded[ADCRP_MSB_LO +: ADCRP_BYTE_W];
			2'h1: byte_val = padded[ADCRP_MID_LO +: ADCRP_BYTE_W];
			2'h2: byte_val = padded[ADCRP_LSB_LO +: ADCRP_BYTE_W];
			default: byte_val = padded[ADCRP_LSB_LO +: ADCRP_BYTE_W];
		endcase
	end

	// Parallel words: upper sixteen bits, then the two low bits left aligned.
	always_comb begin
		if (mode == ADCRP_MODE_BYTE) begin
			word_val = {{(ADCRP_BUS_W-ADCRP_BYTE_W){1'b0}}, byte_val};
		end else if (state_reg.part == ADCRP_PART_FIRST) begin
			word_val = cur_res[ADCRP_RES_W-1 -: ADCRP_BUS_W];
		end else begin
			word_val = {cur_res[ADCRP_LOW_W-1:0], {(ADCRP_BUS_W-ADCRP_LOW_W){1'b0}}};
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_rst = '0;
		state_rst.sync1 = '1;
		state_rst.sync2 = '1;
		state_rst.cs_n_d = 1'b1;
		state_rst.rd_n_d = 1'b1;
		state_rst.db_out = ADCRP_DB_RESET;
		state_rst.db_oe = ADCRP_OE_NONE;
		state_rst.chan = ADCRP_CH_FIRST;
		state_rst.part = ADCRP_PART_FIRST;
		state_next = state_reg;
		// Two flip-flops on every pin before any logic looks at it.
		state_next.sync1.cs_n = cs_n;
		state_next.sync1.rd_n = rd_n;
		state_next.sync1.isel = interface_select_pin;
		state_next.sync1.bsel = byte_or_serial_select_pin;
		state_next.sync1.order = db_in[ADCRP_ORDER_BIT];
		state_next.sync2 = state_reg.sync1;
		state_next.cs_n_d = cs_now;
		state_next.rd_n_d = rd_now;
		if (conv_start) begin
			state_next.busy = 1'b1;
		end
		if (cs_now || !mode_act) begin
			// Frame ended or no active mode: release everything.
			state_next.db_oe = ADCRP_OE_NONE;
			state_next.flag_oe = 1'b0;
			if (cs_rise) begin
				state_next.chan = ADCRP_CH_FIRST;
				state_next.part = ADCRP_PART_FIRST;
			end
		end else begin
			if (cs_fall) begin
				state_next.db_oe = (mode == ADCRP_MODE_BYTE) ? ADCRP_OE_BYTE : ADCRP_OE_WORD;
			end
			if (rd_go) begin
				// Chip select held low needs no edge of its own to open the bus.
				state_next.db_oe = (mode == ADCRP_MODE_BYTE) ? ADCRP_OE_BYTE : ADCRP_OE_WORD;
				state_next.db_out = word_val;
				state_next.flag_oe = 1'b1;
				state_next.flag = (state_reg.chan == ADCRP_CH_FIRST);
				if (state_reg.part >= part_last) begin
					state_next.part = ADCRP_PART_FIRST;
					state_next.chan = state_reg.chan + ADCRP_CH_STEP;
				end else begin
					state_next.part = state_reg.part + ADCRP_PART_STEP;
				end
			end
		end
		// Busy fall wins over any read in the same cycle: new data, fresh pointer.
		if (conv_done) begin
			state_next.busy = 1'b0;
			state_next.bank = conv_data;
			state_next.chan = ADCRP_CH_FIRST;
			state_next.part = ADCRP_PART_FIRST;
		end
		if (!reset_n) begin
			state_next = state_rst;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	// Every output is a field of the state register.
	assign db_out = state_reg.db_out;
	assign db_oe = state_reg.db_oe;
	assign first_channel_flag = state_reg.flag;
	assign first_channel_flag_oe = state_reg.flag_oe;
	assign busy = state_reg.busy;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_load_bank;
		@(posedge clk) disable iff (!reset_n)
		conv_done |=> (state_reg.bank == $past(conv_data)) && !busy;
	endproperty
	a_load_bank: assert property (p_load_bank) else $error("bank not loaded at busy fall");

	property p_hold_bank;
		@(posedge clk) disable iff (!reset_n)
		!conv_done |=> $stable(state_reg.bank);
	endproperty
	a_hold_bank: assert property (p_hold_bank) else $error("bank changed without busy fall");

	property p_serial_quiet;
		@(posedge clk) disable iff (!reset_n)
		(mode == ADCRP_MODE_SER) |=> (db_oe == ADCRP_OE_NONE) && !first_channel_flag_oe;
	endproperty
	a_serial_quiet: assert property (p_serial_quiet) else $error("bus driven in serial mode");

	property p_first_word;
		@(posedge clk) disable iff (!reset_n)
		(rd_go && !conv_done && mode == ADCRP_MODE_PAR && state_reg.chan == ADCRP_CH_FIRST
			&& state_reg.part == ADCRP_PART_FIRST)
		|=> (db_out == $past(state_reg.bank[0][ADCRP_RES_W-1 -: ADCRP_BUS_W]))
			&& (db_oe == ADCRP_OE_WORD);
	endproperty
	a_first_word: assert property (p_first_word) else $error("wrong first parallel word");

	property p_second_word;
		@(posedge clk) disable iff (!reset_n)
		(rd_go && mode == ADCRP_MODE_PAR && state_reg.part == ADCRP_PART_ONE)
		|=> db_out == {$past(cur_res[ADCRP_LOW_W-1:0]), {(ADCRP_BUS_W-ADCRP_LOW_W){1'b0}}};
	endproperty
	a_second_word: assert property (p_second_word) else $error("wrong low-bit word");

	property p_advance;
		@(posedge clk) disable iff (!reset_n)
		(rd_go && !conv_done && state_reg.part == part_last)
		|=> (state_reg.part == ADCRP_PART_FIRST)
			&& (state_reg.chan == $past(state_reg.chan) + ADCRP_CH_STEP);
	endproperty
	a_advance: assert property (p_advance) else $error("channel did not advance");

	property p_flag;
		@(posedge clk) disable iff (!reset_n)
		rd_go |=> first_channel_flag_oe
			&& (first_channel_flag == ($past(state_reg.chan) == ADCRP_CH_FIRST));
	endproperty
	a_flag: assert property (p_flag) else $error("first channel flag wrong");

	property p_release;
		@(posedge clk) disable iff (!reset_n)
		cs_rise |=> (db_oe == ADCRP_OE_NONE) && !first_channel_flag_oe
			&& (state_reg.chan == ADCRP_CH_FIRST) && (state_reg.part == ADCRP_PART_FIRST);
	endproperty
	a_release: assert property (p_release) else $error("frame end did not release");

	property p_byte_last;
		@(posedge clk) disable iff (!reset_n)
		(rd_go && mode == ADCRP_MODE_BYTE && state_reg.sync2.order
			&& state_reg.part == ADCRP_LAST_BYTE)
		|=> (db_out == {8'h00, $past(cur_res[ADCRP_LOW_W-1:0]), 6'h00}) && (db_oe == ADCRP_OE_BYTE);
	endproperty
	a_byte_last: assert property (p_byte_last) else $error("padded last byte wrong");

	property p_byte_reverse;
		@(posedge clk) disable iff (!reset_n)
		(rd_go && mode == ADCRP_MODE_BYTE && !state_reg.sync2.order
			&& state_reg.part == ADCRP_PART_FIRST)
		|=> db_out == {8'h00, $past(cur_res[ADCRP_LOW_W-1:0]), 6'h00};
	endproperty
	a_byte_reverse: assert property (p_byte_reverse) else $error("reversed order wrong");

	property p_busy_pointer;
		@(posedge clk) disable iff (!reset_n)
		conv_done |=> (state_reg.chan == ADCRP_CH_FIRST) && (state_reg.part == ADCRP_PART_FIRST);
	endproperty
	a_busy_pointer: assert property (p_busy_pointer) else $error("pointer not reset");

	property p_busy_rise;
		@(posedge clk) disable iff (!reset_n)
		(conv_start && !conv_done) |=> busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");

endmodule

`default_nettype wire
